/* logic/slcr_top.v */
// Purpose: APB register bank for link status and configuration of a switch node
// Assumes: Link engines are on mclk; their status inputs pass a two-flop synchroniser anyway
// Notes: Status, configs and commands for eight links are flat vectors, link n at slice n
`timescale 1ns/1ns
`include "slcr_regs.vh"

// ****************************************
// Two-flop synchroniser
// ****************************************
module slcr_sync #(
   parameter WIDTH = 1
) (
   input wire mclk,
   input wire reset_n,
   input wire [WIDTH-1:0] din,
   output reg [WIDTH-1:0] sync_ff
);
   reg [WIDTH-1:0] meta_ff;

   // Only the second stage leaves the module; the first may go metastable
   // Reset clears both stages so no stale status shows after reset
   always @(posedge mclk) begin
      if (!reset_n) begin
         meta_ff <= {WIDTH{1'b0}};
         sync_ff <= {WIDTH{1'b0}};
      end else begin
         meta_ff <= din;
         sync_ff <= meta_ff;
      end
   end
endmodule

// ****************************************
// Per-link configuration and status slice
// ****************************************
module slcr_link (
   input wire mclk,
   input wire reset_n,
   input wire wr_pl,
   input wire wr_xl,
   input wire wr_st,
   input wire [31:0] wdata,
   input wire [16:0] raw_sts,
   input wire err_evt,
   output reg [31:0] pl_rd,
   output reg [31:0] xl_rd,
   output reg [31:0] st_rd,
   output reg link_en_ff,
   output reg wide_ff,
   output reg credit_request_token_ff,
   output reg rxrst_ff,
   output reg [10:0] sym_gap_ff,
   output reg [10:0] tok_gap_ff,
   output reg [1:0] net_ff,
   output reg st_en_ff,
   output reg st_proc_ff,
   output reg [4:0] st_cend_ff,
   output reg err_ff
);
   // Status word: [16:15] type, [14:7] dest, [6] junk, [5] dst use, [4] src use,
   // [3] credit issued, [2] credit held, [1:0] spare
   wire [16:0] sync2_ff;
   wire err2_ff;

   // Two flops before any read: the link engine may sit on another clock
   slcr_sync #(
      .WIDTH(17)
   ) u_sts_sync (
      .mclk(mclk),
      .reset_n(reset_n),
      .din(raw_sts),
      .sync_ff(sync2_ff)
   );
   slcr_sync #(
      .WIDTH(1)
   ) u_err_sync (
      .mclk(mclk),
      .reset_n(reset_n),
      .din(err_evt),
      .sync_ff(err2_ff)
   );

   // Writable fields; reserved bits are never stored
   always @(posedge mclk) begin
      if (!reset_n) begin
         net_ff <= `SLCR_RST_NET;
         link_en_ff <= 1'b0;
         wide_ff <= 1'b0;
         sym_gap_ff <= `SLCR_RST_GAP;
         tok_gap_ff <= `SLCR_RST_GAP;
         credit_request_token_ff <= 1'b0;
         rxrst_ff <= 1'b0;
         st_en_ff <= 1'b0;
         st_proc_ff <= 1'b0;
         st_cend_ff <= `SLCR_RST_CEND;
         err_ff <= 1'b0;
      end else begin
         if (wr_pl) begin
            net_ff <= wdata[`SLCR_PL_NET_HI:`SLCR_PL_NET_LO];
         end
         // Gap fields are passed on as written; the link engine adds the one
         if (wr_xl) begin
            link_en_ff <= wdata[`SLCR_XL_EN];
            wide_ff <= wdata[`SLCR_XL_WIDE];
            sym_gap_ff <= wdata[`SLCR_XL_SYM_HI:`SLCR_XL_SYM_LO];
            tok_gap_ff <= wdata[`SLCR_XL_TOK_HI:`SLCR_XL_TOK_LO];
         end
         // One-cycle command pulses to the link engine
         credit_request_token_ff <= wr_xl & wdata[`SLCR_XL_CREDIT_REQUEST_TOKEN];
         rxrst_ff <= wr_xl & wdata[`SLCR_XL_RXRST];
         if (wr_st) begin
            st_en_ff <= wdata[`SLCR_ST_EN];
            st_proc_ff <= wdata[`SLCR_ST_PROC];
            st_cend_ff <= wdata[`SLCR_ST_CEND_HI:`SLCR_ST_CEND_LO];
         end
         // Error latches until the receiver is reset; a new error wins
         if (err2_ff) begin
            err_ff <= 1'b1;
         end else if (wr_xl & wdata[`SLCR_XL_RXRST]) begin
            err_ff <= 1'b0;
         end
      end
   end

   // Read views; command and reserved bits are zero
   always @* begin
      pl_rd = 32'h00000000;
      pl_rd[`SLCR_PL_TYPE_HI:`SLCR_PL_TYPE_LO] = sync2_ff[16:15];
      // Destination only meaningful while in use
      pl_rd[`SLCR_PL_DEST_HI:`SLCR_PL_DEST_LO] =
         (sync2_ff[5] | sync2_ff[4]) ? sync2_ff[14:7] : 8'h00;
      pl_rd[`SLCR_PL_NET_HI:`SLCR_PL_NET_LO] = net_ff;
      pl_rd[`SLCR_PL_JUNK] = sync2_ff[6];
      pl_rd[`SLCR_PL_DST_USE] = sync2_ff[5];
      pl_rd[`SLCR_PL_SRC_USE] = sync2_ff[4];
      // Configuration view; bits 24 and 23 are commands and read zero
      xl_rd = 32'h00000000;
      xl_rd[`SLCR_XL_EN] = link_en_ff;
      xl_rd[`SLCR_XL_WIDE] = wide_ff;
      xl_rd[`SLCR_XL_ERR] = err_ff;
      xl_rd[`SLCR_XL_CRED_OUT] = sync2_ff[3];
      xl_rd[`SLCR_XL_CRED_IN] = sync2_ff[2];
      xl_rd[`SLCR_XL_SYM_HI:`SLCR_XL_SYM_LO] = sym_gap_ff;
      xl_rd[`SLCR_XL_TOK_HI:`SLCR_XL_TOK_LO] = tok_gap_ff;
      // Static view; reserved bits 30:9 and 7:5 read zero
      st_rd = 32'h00000000;
      st_rd[`SLCR_ST_EN] = st_en_ff;
      st_rd[`SLCR_ST_PROC] = st_proc_ff;
      st_rd[`SLCR_ST_CEND_HI:`SLCR_ST_CEND_LO] = st_cend_ff;
   end
endmodule

// ****************************************
// Top: APB slave, decode, interrupt
// ****************************************
module slcr_top #(
   parameter NLINK = 8
) (
   input wire mclk,
   input wire reset_n,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   input wire [17*NLINK-1:0] link_sts,
   input wire [NLINK-1:0] link_err,
   output reg [NLINK-1:0] link_en,
   output reg [NLINK-1:0] link_wide,
   output reg [NLINK-1:0] link_credit_request_token,
   output reg [NLINK-1:0] link_rx_reset,
   output reg [11*NLINK-1:0] link_sym_gap,
   output reg [11*NLINK-1:0] link_tok_gap,
   output reg [2*NLINK-1:0] link_network,
   output reg [NLINK-1:0] static_en,
   output reg [NLINK-1:0] static_proc,
   output reg [5*NLINK-1:0] static_cend,
   output reg irq
);
   // Bus decode
   wire [9:0] idx;
   wire [7:0] sub;
   wire acc;

   // Per-slice write strobes and read views
   wire [NLINK-1:0] wr_pl;
   wire [NLINK-1:0] wr_xl;
   wire [NLINK-1:0] wr_st;
   wire [32*NLINK-1:0] pl_rd;
   wire [32*NLINK-1:0] xl_rd;
   wire [32*NLINK-1:0] st_rd;

   // Slice fields on their way to the output flops
   wire [NLINK-1:0] en_w;
   wire [NLINK-1:0] wide_w;
   wire [NLINK-1:0] credit_request_token_w;
   wire [NLINK-1:0] rxrst_w;
   wire [11*NLINK-1:0] sym_w;
   wire [11*NLINK-1:0] tok_w;
   wire [2*NLINK-1:0] net_w;
   wire [NLINK-1:0] sten_w;
   wire [NLINK-1:0] stproc_w;
   wire [5*NLINK-1:0] stcend_w;
   wire [NLINK-1:0] err_w;

   // Interrupt state; err_q_ff holds last cycle's error level for edge detection
   reg [NLINK-1:0] err_q_ff;
   reg [NLINK-1:0] irq_sts_ff;
   reg [NLINK-1:0] irq_msk_ff;

   // Read mux result
   reg [31:0] nxt_prdata;
   reg nxt_err;
   integer k;

   // Register map, byte address = four times the index, paddr[11:10] zero:
   //    0x100 + 4n  processor-link status and network, link n
   //    0x200 + 4n  external-link configuration, link n
   //    0x280 + 4n  static forwarding, slot n
   //    0x300       interrupt status, bit n = link n error, write one to clear
   //    0x304       interrupt mask
   // Anything else reads zero and answers with pslverr
   assign idx = paddr[11:2];
   assign sub = idx[7:0];
   // Access phase accepted in the cycle it starts; pready answers one cycle later
   assign acc = psel & penable & ~pready;

   // Register slices, one per link; static slot n belongs to link C,D,A,B,G,H,E,F
   genvar g;
   generate
      for (g = 0; g < NLINK; g = g + 1) begin : gl
         assign wr_pl[g] = acc & pwrite & (idx[9:8] == 2'h0)
            & (sub == (`SLCR_IDX_PROC + g));
         assign wr_xl[g] = acc & pwrite & (idx[9:8] == 2'h0)
            & (sub == (`SLCR_IDX_XLINK + g));
         assign wr_st[g] = acc & pwrite & (idx[9:8] == 2'h0)
            & (sub == (`SLCR_IDX_STAT + g));
         slcr_link u_link (
            .mclk(mclk),
            .reset_n(reset_n),
            .wr_pl(wr_pl[g]),
            .wr_xl(wr_xl[g]),
            .wr_st(wr_st[g]),
            .wdata(pwdata),
            .raw_sts(link_sts[17*g+16:17*g]),
            .err_evt(link_err[g]),
            .pl_rd(pl_rd[32*g+31:32*g]),
            .xl_rd(xl_rd[32*g+31:32*g]),
            .st_rd(st_rd[32*g+31:32*g]),
            .link_en_ff(en_w[g]),
            .wide_ff(wide_w[g]),
            .credit_request_token_ff(credit_request_token_w[g]),
            .rxrst_ff(rxrst_w[g]),
            .sym_gap_ff(sym_w[11*g+10:11*g]),
            .tok_gap_ff(tok_w[11*g+10:11*g]),
            .net_ff(net_w[2*g+1:2*g]),
            .st_en_ff(sten_w[g]),
            .st_proc_ff(stproc_w[g]),
            .st_cend_ff(stcend_w[5*g+4:5*g]),
            .err_ff(err_w[g])
         );
      end
   endgenerate

   // Read mux; unmapped addresses answer zero with pslverr
   always @* begin
      nxt_prdata = 32'h00000000;
      nxt_err = 1'b1;
      // Later matches win; the ranges never overlap, so the order is immaterial
      for (k = 0; k < NLINK; k = k + 1) begin
         if (idx[9:8] == 2'h0 && sub == (`SLCR_IDX_PROC + k)) begin
            nxt_prdata = pl_rd[32*k +: 32];
            nxt_err = 1'b0;
         end
         if (idx[9:8] == 2'h0 && sub == (`SLCR_IDX_XLINK + k)) begin
            nxt_prdata = xl_rd[32*k +: 32];
            nxt_err = 1'b0;
         end
         if (idx[9:8] == 2'h0 && sub == (`SLCR_IDX_STAT + k)) begin
            nxt_prdata = st_rd[32*k +: 32];
            nxt_err = 1'b0;
         end
      end
      if (idx[9:8] == 2'h0 && sub == `SLCR_IDX_IRQ_STS) begin
         nxt_prdata[NLINK-1:0] = irq_sts_ff;
         nxt_err = 1'b0;
      end
      if (idx[9:8] == 2'h0 && sub == `SLCR_IDX_IRQ_MSK) begin
         nxt_prdata[NLINK-1:0] = irq_msk_ff;
         nxt_err = 1'b0;
      end
   end

   // APB answer, interrupt status and mask
   always @(posedge mclk) begin
      if (!reset_n) begin
         prdata <= 32'h00000000;
         pready <= 1'b0;
         pslverr <= 1'b0;
         err_q_ff <= {NLINK{1'b0}};
         irq_sts_ff <= {NLINK{1'b0}};
         irq_msk_ff <= {NLINK{1'b0}};
         irq <= 1'b0;
      end else begin
         // One wait state: the answer flops load on the take edge
         // prdata is zero outside a read answer so stale data never shows
         pready <= acc;
         pslverr <= acc & nxt_err;
         prdata <= (acc & ~pwrite) ? nxt_prdata : 32'h00000000;
         err_q_ff <= err_w;
         // Rising error sets status; set beats a same-cycle write-one clear
         if (acc & pwrite & (idx[9:8] == 2'h0) & (sub == `SLCR_IDX_IRQ_STS)) begin
            irq_sts_ff <= (irq_sts_ff & ~pwdata[NLINK-1:0]) | (err_w & ~err_q_ff);
         end else begin
            irq_sts_ff <= irq_sts_ff | (err_w & ~err_q_ff);
         end
         if (acc & pwrite & (idx[9:8] == 2'h0) & (sub == `SLCR_IDX_IRQ_MSK)) begin
            irq_msk_ff <= pwdata[NLINK-1:0];
         end
         irq <= |(irq_sts_ff & irq_msk_ff);
      end
   end

   // Link-facing outputs, registered once more so they come from flops
   // The extra flop delays each field by a cycle; reads see the slice register,
   // so software never observes this lag
   always @(posedge mclk) begin
      if (!reset_n) begin
         link_en <= {NLINK{1'b0}};
         link_wide <= {NLINK{1'b0}};
         link_credit_request_token <= {NLINK{1'b0}};
         link_rx_reset <= {NLINK{1'b0}};
         link_sym_gap <= {11*NLINK{1'b0}};
         link_tok_gap <= {11*NLINK{1'b0}};
         link_network <= {2*NLINK{1'b0}};
         static_en <= {NLINK{1'b0}};
         static_proc <= {NLINK{1'b0}};
         static_cend <= {5*NLINK{1'b0}};
      end else begin
         link_en <= en_w;
         link_wide <= wide_w;
         link_credit_request_token <= credit_request_token_w;
         link_rx_reset <= rxrst_w;
         link_sym_gap <= sym_w;
         link_tok_gap <= tok_w;
         link_network <= net_w;
         static_en <= sten_w;
         static_proc <= stproc_w;
         static_cend <= stcend_w;
      end
   end
endmodule

/* logic/slcr_regs.vh */
// Purpose: Register offsets, field positions and reset values of the link config registers
// Assumes: Registers are addressed by index; byte address is four times the index
// Notes: Definitions only
`ifndef SLCR_REGS_VH
`define SLCR_REGS_VH
// Register indices, eight of each per-link group; interrupt status and mask one each
`define SLCR_IDX_PROC 8'h40
`define SLCR_IDX_XLINK 8'h80
`define SLCR_IDX_STAT 8'ha0
`define SLCR_IDX_IRQ_STS 8'hc0
`define SLCR_IDX_IRQ_MSK 8'hc1
// Processor-link status fields
`define SLCR_PL_TYPE_HI 25
`define SLCR_PL_TYPE_LO 24
`define SLCR_PL_DEST_HI 23
`define SLCR_PL_DEST_LO 16
`define SLCR_PL_NET_HI 5
`define SLCR_PL_NET_LO 4
`define SLCR_PL_JUNK 2
`define SLCR_PL_DST_USE 1
`define SLCR_PL_SRC_USE 0
// External-link configuration fields
`define SLCR_XL_EN 31
`define SLCR_XL_WIDE 30
`define SLCR_XL_ERR 27
`define SLCR_XL_CRED_OUT 26
`define SLCR_XL_CRED_IN 25
`define SLCR_XL_CREDIT_REQUEST_TOKEN 24
`define SLCR_XL_RXRST 23
`define SLCR_XL_SYM_HI 21
`define SLCR_XL_SYM_LO 11
`define SLCR_XL_TOK_HI 10
`define SLCR_XL_TOK_LO 0
// Static-link fields
`define SLCR_ST_EN 31
`define SLCR_ST_PROC 8
`define SLCR_ST_CEND_HI 4
`define SLCR_ST_CEND_LO 0
// Reset values
`define SLCR_RST_NET 2'h0
`define SLCR_RST_GAP 11'h000
`define SLCR_RST_CEND 5'h00
`endif

/* test/slcr_top_assertions.sv */
// Purpose: Port checks of the link config register bank
// Assumes: One clock, synchronous active-low reset
// Notes: Link 0 and slot 0 stand for every slice
`timescale 1ns/1ns
// ****************
// Checker
// ****************
module slcr_chk #(
   parameter NLINK = 8
) (
   input wire mclk,
   input wire reset_n,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   input wire [31:0] prdata,
   input wire pready,
   input wire pslverr,
   input wire [NLINK-1:0] link_en,
   input wire [NLINK-1:0] link_wide,
   input wire [NLINK-1:0] link_credit_request_token,
   input wire [NLINK-1:0] link_rx_reset,
   input wire [11*NLINK-1:0] link_sym_gap,
   input wire [11*NLINK-1:0] link_tok_gap,
   input wire [2*NLINK-1:0] link_network,
   input wire [NLINK-1:0] static_en,
   input wire [NLINK-1:0] static_proc,
   input wire [5*NLINK-1:0] static_cend
);
   // Completed writes per register, decoded once
   wire wr_done = psel & penable & pwrite & pready;
   wire xl_wr = wr_done & (paddr == 12'h200);
   wire credit_request_token_req = xl_wr & pwdata[24];
   default clocking @(posedge mclk); endclocking
   default disable iff (!reset_n);
   a_one_wait: assert property (psel && penable && !pready |=> pready)
      else $error("ready late");
   a_ready_pulse: assert property (pready |=> !pready) else $error("ready held");
   a_err_ready: assert property (pslverr |-> pready) else $error("lone slverr");
   a_rdata_idle: assert property (!pready |-> prdata == 32'h0) else $error("stray rdata");
   a_link_mode: assert property (xl_wr |=> link_en[0] == $past(pwdata[31]) &&
      link_wide[0] == $past(pwdata[30])) else $error("enable or width wrong");
   a_credit_request_token_cause: assert property (credit_request_token_req |=> link_credit_request_token[0]) else $error("no credit_request_token");
   a_credit_request_token_only: assert property (link_credit_request_token[0] |-> $past(credit_request_token_req)) else $error("bad credit_request_token");
   a_rx_reset: assert property (xl_wr && pwdata[23] |=> link_rx_reset[0])
      else $error("no rx reset");
   a_gap_fields: assert property (xl_wr |=> link_sym_gap[10:0] == $past(pwdata[21:11]) &&
      link_tok_gap[10:0] == $past(pwdata[10:0])) else $error("gap wrong");
   a_static_route: assert property (wr_done && paddr == 12'h280 |=>
      static_en[0] == $past(pwdata[31]) && static_proc[0] == $past(pwdata[8]) &&
      static_cend[4:0] == $past(pwdata[4:0])) else $error("static wrong");
   a_net_field: assert property (wr_done && paddr == 12'h100 |=>
      link_network[1:0] == $past(pwdata[5:4])) else $error("network wrong");
endmodule

bind slcr_top slcr_chk #(.NLINK(NLINK)) u_chk (.mclk(mclk), .reset_n(reset_n), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .link_en(link_en), .link_wide(link_wide),
   .link_credit_request_token(link_credit_request_token), .link_rx_reset(link_rx_reset), .link_sym_gap(link_sym_gap),
   .link_tok_gap(link_tok_gap), .link_network(link_network), .static_en(static_en),
   .static_proc(static_proc), .static_cend(static_cend));

/* test/slcr_far.sv */
// Purpose: Link engines and remote node seen from the register bank
// Assumes: Remote answers a credit request after DLY clocks
// Notes: Busy, junk and error are steered by the bench
`timescale 1ns/1ns
// ****************
// Far-side model
// ****************
module slcr_far #(
   parameter NLINK = 8,
   parameter DLY = 20
) (
   input wire mclk,
   input wire reset_n,
   input wire [NLINK-1:0] link_en,
   input wire [NLINK-1:0] link_credit_request_token,
   input wire [NLINK-1:0] busy,
   input wire [NLINK-1:0] junk,
   input wire [NLINK-1:0] err_req,
   output reg [17*NLINK-1:0] link_sts,
   output reg [NLINK-1:0] link_err
);
   integer n;
   reg [7:0] wait_ff [0:NLINK-1];
   // A credit request drops held credit until the remote replies
   always @(posedge mclk) begin
      link_err <= err_req;
      for (n = 0; n < NLINK; n = n + 1) begin
         if (!reset_n || link_credit_request_token[n]) wait_ff[n] <= DLY;
         else if (wait_ff[n] != 8'h0) wait_ff[n] <= wait_ff[n] - 8'h1;
         link_sts[17*n +: 17] <= !reset_n ? 17'h0 : {n[1:0], n[7:0] + 8'h10, junk[n],
            busy[n], busy[n], link_en[n], link_en[n] && wait_ff[n] == 8'h0, 2'b00};
      end
   end
endmodule

/* test/tb_switch_link_config_regs.sv */
// Purpose: Register bench for the link config bank over APB
// Assumes: One wait state per access, far model on every link
// Notes: Expected words are built from field positions
`timescale 1ns/1ns
// ****************
// Bench
// ****************
module tb_switch_link_config_regs;
   reg mclk = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0, ev;
   reg [11:0] paddr = 12'h0;
   reg [31:0] pwdata = 32'h0, rv;
   reg [7:0] busy = 8'h0, junk = 8'h0, err_req = 8'h0;
   wire [31:0] prdata;
   wire pready, pslverr, irq;
   wire [135:0] link_sts;
   wire [7:0] link_err, link_en, link_wide, link_credit_request_token, link_rx_reset, static_en, static_proc;
   wire [87:0] link_sym_gap, link_tok_gap;
   wire [15:0] link_network;
   wire [39:0] static_cend;
   integer err_count = 0, cmp_count = 0, n, k;
   initial forever #10 mclk = ~mclk;
   slcr_top dut (.mclk(mclk), .reset_n(reset_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .link_sts(link_sts), .link_err(link_err), .link_en(link_en),
      .link_wide(link_wide), .link_credit_request_token(link_credit_request_token), .link_rx_reset(link_rx_reset),
      .link_sym_gap(link_sym_gap), .link_tok_gap(link_tok_gap), .link_network(link_network),
      .static_en(static_en), .static_proc(static_proc), .static_cend(static_cend), .irq(irq));
   slcr_far far (.mclk(mclk), .reset_n(reset_n), .link_en(link_en), .link_credit_request_token(link_credit_request_token),
      .busy(busy), .junk(junk), .err_req(err_req), .link_sts(link_sts), .link_err(link_err));
   task results; begin
      $display("compares %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   end endtask
   task chk(input [31:0] got, input [31:0] exp); begin
      cmp_count = cmp_count + 1;
      if (got !== exp) begin
         err_count = err_count + 1;
         $display("Error %0t got %h expected %h", $time, got, exp);
      end
   end endtask
   // One APB transfer; request held until pready is seen high
   task apb(input w, input integer a, input [31:0] d); begin
      psel <= 1'b1; pwrite <= w; paddr <= a[11:0]; pwdata <= d;
      @(posedge mclk); penable <= 1'b1; k = 0;
      @(posedge mclk);
      while (pready !== 1'b1 && k < 20) begin k = k + 1; @(posedge mclk); end
      if (k == 20) begin err_count = err_count + 1; results; end
      rv = prdata; ev = pslverr; psel <= 1'b0; penable <= 1'b0;
      @(posedge mclk);
   end endtask
   task rd(input integer a, input [31:0] exp); begin apb(0, a, 32'h0); chk(rv, exp); end endtask
   // Main sequence, one group of calls per test
   initial begin
      repeat (16) @(posedge mclk);
      reset_n <= 1'b1;
      @(posedge mclk);
      for (n = 0; n < 8; n = n + 1) begin
         rd('h100 + 4*n, {6'h0, n[1:0], 24'h0});
         rd('h200 + 4*n, 32'h0);
         rd('h280 + 4*n, 32'h0);
      end
      $display("test reset values done");
      for (n = 0; n < 8; n = n + 1) begin
         apb(1, 'h100 + 4*n, 32'hffffffff);
         rd('h100 + 4*n, {6'h0, n[1:0], 24'h30});
         apb(1, 'h280 + 4*n, 32'hffff_fe00 | n);
         rd('h280 + 4*n, 32'h8000_0000 | n);
         chk({26'h0, static_en[n], static_cend[5*n +: 5]}, 32'h20 | n);
         apb(1, 'h200 + 4*n, 32'h7fffffff);
         rd('h200 + 4*n, 32'h403fffff);
         chk({link_sym_gap[11*n +: 11], link_tok_gap[11*n +: 11]}, 32'h3fffff);
      end
      $display("test field write done");
      apb(1, 'h204, 32'h80000000);
      repeat (30) @(posedge mclk);
      rd('h204, 32'h86000000);
      apb(1, 'h204, 32'h81000000);
      repeat (6) @(posedge mclk);
      rd('h204, 32'h84000000);
      repeat (30) @(posedge mclk);
      rd('h204, 32'h86000000);
      $display("test credit done");
      busy <= 8'hff;
      junk <= 8'hff;
      repeat (4) @(posedge mclk);
      for (n = 0; n < 8; n = n + 1)
         rd('h100 + 4*n, {6'h0, n[1:0], n[7:0] + 8'h10, 16'h0037});
      busy <= 8'h0;
      junk <= 8'h0;
      $display("test link status done");
      apb(1, 'h304, 32'h1);
      err_req <= 8'h03;
      @(posedge mclk);
      err_req <= 8'h0;
      repeat (6) @(posedge mclk);
      chk({31'h0, irq}, 32'h1);
      rd('h300, 32'h3);
      rd('h200, 32'h483fffff);
      apb(1, 'h300, 32'h1);
      repeat (3) @(posedge mclk);
      chk({31'h0, irq}, 32'h0);
      rd('h300, 32'h2);
      apb(1, 'h200, 32'h40800000);
      rd('h200, 32'h40000000);
      $display("test error and interrupt done");
      apb(0, 'h400, 32'h0);
      chk({ev, rv[30:0]}, 32'h80000000);
      $display("test unmapped done");
      results;
   end
   // Watchdog for a run that stops making progress
   initial begin
      #1000000;
      err_count = err_count + 1;
      results;
   end
endmodule
